// File: logic/bdcr_defines.svh
// offsets, field positions, reset values and timing counts of the bridge config bank
`ifndef BDCR_DEFINES_SVH
`define BDCR_DEFINES_SVH

`define BDCR_ADDR_LOCK 6'h08
`define BDCR_ADDR_PIN_OVR 6'h09
`define BDCR_ADDR_CFG1 6'h0a
`define BDCR_ADDR_CFG2 6'h0b
`define BDCR_ADDR_CFG3 6'h0c
`define BDCR_ADDR_CFG4 6'h0d

`define BDCR_RST_CFG1 8'h10
`define BDCR_RST_CFG2 8'h00
`define BDCR_RST_CFG3 8'h40
`define BDCR_RST_CFG4 8'h04
`define BDCR_RST_LOCK 8'h09
`define BDCR_RST_PIN_OVR 8'h0c

`define BDCR_MASK_CFG1 8'hff
`define BDCR_MASK_CFG2 8'he7
`define BDCR_MASK_CFG3 8'hdf
`define BDCR_MASK_CFG4 8'hdf
`define BDCR_MASK_LOCK 8'h1b
`define BDCR_MASK_PIN_OVR 8'h0f

`define BDCR_CODE_UNLOCK_OR_LOCK 2'h2
`define BDCR_CFG_LOCK_LSB 0
`define BDCR_PIN_LOCK_LSB 3

`define BDCR_OLA_EN_BIT 7
`define BDCR_OV_SEL_LSB 5
`define BDCR_SPREAD_SPECTRUM_DISABLE_BIT 4
`define BDCR_OVERCURRENT_RETRY_BIT 3
`define BDCR_OVERTEMP_RETRY_BIT 2
`define BDCR_OV_RETRY_BIT 1
`define BDCR_OPEN_LOAD_RETRY_BIT 0
`define BDCR_PWM_EXT_BIT 7
`define BDCR_LOAD_LSB 5
`define BDCR_CURRENT_TRIP_LSB 0
`define BDCR_REGULATION_OFF_TIME_LSB 6
`define BDCR_SR_LSB 2
`define BDCR_MODE_LSB 0
`define BDCR_TOCP_LSB 6
`define BDCR_OVERCURRENT_THRESHOLD_SELECT_LSB 3
`define BDCR_SHUT_SEL_BIT 2
`define BDCR_IN1_SEL_BIT 1
`define BDCR_IN2_SEL_BIT 0
`define BDCR_OVR_SHUT_BIT 3
`define BDCR_OVR_IN1_BIT 1
`define BDCR_OVR_IN2_BIT 0

`define BDCR_LOAD_LOW_SIDE 2'h1
`define BDCR_EXT_LOGIC_RAIL 1'b1

`define BDCR_CLK_MHZ 20
`define BDCR_REGULATION_OFF_TIME_US_0 20
`define BDCR_REGULATION_OFF_TIME_US_1 30
`define BDCR_REGULATION_OFF_TIME_US_2 40
`define BDCR_REGULATION_OFF_TIME_US_3 50
`define BDCR_TOCP_NS_0 6000
`define BDCR_TOCP_NS_1 3000
`define BDCR_TOCP_NS_2 1500
`define BDCR_TOCP_NS_3 200
`define BDCR_US_CYC(us) ((us) * `BDCR_CLK_MHZ)
`define BDCR_NS_CYC(ns) (((ns) * `BDCR_CLK_MHZ) / 1000)

`define BDCR_PCT_100 7'h64
`define BDCR_PCT_75 7'h4b
`define BDCR_PCT_50 7'h32

`endif

// File: logic/bdcr_pkg.sv
// types of the bridge driver configuration bank
package bdcr_pkg;

    typedef struct packed {
        logic wr;
        logic rd;
        logic [5:0] addr;
        logic [7:0] wdata;
    } bdcr_req_t;

    typedef enum logic [1:0] {
        BDCR_MODE_PHEN = 2'b00,
        BDCR_MODE_PWM = 2'b01,
        BDCR_MODE_INDEP = 2'b10,
        BDCR_MODE_RSVD = 2'b11
    } bdcr_mode_t;

    typedef struct packed {
        logic shutoff;
        logic in1;
        logic in2;
    } bdcr_pins_t;

endpackage

// File: logic/bdcr_config_regs.sv
// configuration register bank of the motor-bridge driver
`timescale 1ns/1ps
`include "bdcr_defines.svh"

module bdcr_config_regs
    import bdcr_pkg::*;
(
    input wire logic i_clk,
    input wire logic i_rst_n,
    input wire bdcr_req_t i_req,
    input wire bdcr_pins_t i_pins,
    output logic [7:0] o_rdata,
    output logic o_open_load_active_enable,
    output logic [1:0] o_overvoltage_threshold_select,
    output logic o_overvoltage_monitor_enable,
    output logic o_spread_spectrum_enable,
    output logic o_overcurrent_retry,
    output logic o_overtemp_retry,
    output logic o_overvoltage_retry,
    output logic o_undervoltage_retry,
    output logic o_open_load_retry,
    output logic o_pwm_coast_extend,
    output logic [1:0] o_load_type_select,
    output logic [2:0] o_current_trip_level,
    output logic [10:0] o_regulation_off_time_cycles,
    output logic [2:0] o_slew_rate_select,
    output bdcr_mode_t o_bridge_mode,
    output logic [7:0] o_overcurrent_filter_cycles,
    output logic [6:0] o_overcurrent_threshold_pct,
    output logic o_cfg_locked,
    output logic o_pin_override_unlocked,
    output bdcr_pins_t o_pins_eff
);

    ////////////////////////////////////////////////////////////////////////////
    // pin combine and time tables

    function automatic logic combine(input logic sel, input logic pin, input logic reg_bit);
        combine = sel ? (pin & reg_bit) : (pin | reg_bit);
    endfunction

    localparam logic [10:0] REGULATION_OFF_TIME_C0 = 11'(`BDCR_US_CYC(`BDCR_REGULATION_OFF_TIME_US_0));
    localparam logic [10:0] REGULATION_OFF_TIME_C1 = 11'(`BDCR_US_CYC(`BDCR_REGULATION_OFF_TIME_US_1));
    localparam logic [10:0] REGULATION_OFF_TIME_C2 = 11'(`BDCR_US_CYC(`BDCR_REGULATION_OFF_TIME_US_2));
    localparam logic [10:0] REGULATION_OFF_TIME_C3 = 11'(`BDCR_US_CYC(`BDCR_REGULATION_OFF_TIME_US_3));
    localparam logic [7:0] TOCP_C0 = 8'(`BDCR_NS_CYC(`BDCR_TOCP_NS_0));
    localparam logic [7:0] TOCP_C1 = 8'(`BDCR_NS_CYC(`BDCR_TOCP_NS_1));
    localparam logic [7:0] TOCP_C2 = 8'(`BDCR_NS_CYC(`BDCR_TOCP_NS_2));
    localparam logic [7:0] TOCP_C3 = 8'(`BDCR_NS_CYC(`BDCR_TOCP_NS_3));

    ////////////////////////////////////////////////////////////////////////////
    // registers

    logic [7:0] cfg1_q;
    logic [7:0] cfg2_q;
    logic [7:0] cfg3_q;
    logic [7:0] cfg4_q;
    logic [7:0] lock_q;
    logic [7:0] ovr_q;
    bdcr_pins_t pins_s1_q;
    bdcr_pins_t pins_s2_q;

    wire logic [1:0] cfg_lock_code = lock_q[`BDCR_CFG_LOCK_LSB +: 2];
    wire logic [1:0] pin_lock_code = lock_q[`BDCR_PIN_LOCK_LSB +: 2];
    wire logic cfg_locked = (cfg_lock_code == `BDCR_CODE_UNLOCK_OR_LOCK);
    wire logic pin_unlocked = (pin_lock_code == `BDCR_CODE_UNLOCK_OR_LOCK);
    wire logic cfg_wr_ok = i_req.wr & ~cfg_locked;

    wire logic wr_cfg1 = cfg_wr_ok & (i_req.addr == `BDCR_ADDR_CFG1);
    wire logic wr_cfg2 = cfg_wr_ok & (i_req.addr == `BDCR_ADDR_CFG2);
    wire logic wr_cfg3 = cfg_wr_ok & (i_req.addr == `BDCR_ADDR_CFG3);
    wire logic wr_cfg4 = cfg_wr_ok & (i_req.addr == `BDCR_ADDR_CFG4);
    wire logic wr_lock = i_req.wr & (i_req.addr == `BDCR_ADDR_LOCK);
    wire logic wr_ovr = i_req.wr & (i_req.addr == `BDCR_ADDR_PIN_OVR);

    wire logic [7:0] cfg1_d = wr_cfg1 ? (i_req.wdata & `BDCR_MASK_CFG1) : cfg1_q;
    wire logic [7:0] cfg2_d = wr_cfg2 ? (i_req.wdata & `BDCR_MASK_CFG2) : cfg2_q;
    wire logic [7:0] cfg3_d = wr_cfg3 ? (i_req.wdata & `BDCR_MASK_CFG3) : cfg3_q;
    wire logic [7:0] cfg4_d = wr_cfg4 ? (i_req.wdata & `BDCR_MASK_CFG4) : cfg4_q;
    wire logic [7:0] lock_d = wr_lock ? (i_req.wdata & `BDCR_MASK_LOCK) : lock_q;
    wire logic [7:0] ovr_d = wr_ovr ? (i_req.wdata & `BDCR_MASK_PIN_OVR) : ovr_q;

    always_ff @(posedge i_clk or negedge i_rst_n)
    begin
        if (!i_rst_n)
        begin
            cfg1_q <= `BDCR_RST_CFG1;
            cfg2_q <= `BDCR_RST_CFG2;
            cfg3_q <= `BDCR_RST_CFG3;
            cfg4_q <= `BDCR_RST_CFG4;
            lock_q <= `BDCR_RST_LOCK;
            ovr_q <= `BDCR_RST_PIN_OVR;
        end
        else
        begin
            cfg1_q <= cfg1_d;
            cfg2_q <= cfg2_d;
            cfg3_q <= cfg3_d;
            cfg4_q <= cfg4_d;
            lock_q <= lock_d;
            ovr_q <= ovr_d;
        end
    end

    // pin synchroniser
    always_ff @(posedge i_clk or negedge i_rst_n)
    begin
        if (!i_rst_n)
        begin
            pins_s1_q <= '0;
            pins_s2_q <= '0;
        end
        else
        begin
            pins_s1_q <= i_pins;
            pins_s2_q <= pins_s1_q;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // read mux and decoded settings

    logic [7:0] rdata_d;
    always_comb
    begin
        case (i_req.addr)
            `BDCR_ADDR_LOCK: rdata_d = lock_q;
            `BDCR_ADDR_PIN_OVR: rdata_d = ovr_q;
            `BDCR_ADDR_CFG1: rdata_d = cfg1_q;
            `BDCR_ADDR_CFG2: rdata_d = cfg2_q;
            `BDCR_ADDR_CFG3: rdata_d = cfg3_q;
            `BDCR_ADDR_CFG4: rdata_d = cfg4_q;
            default: rdata_d = 8'h00;
        endcase
    end

    wire bdcr_mode_t mode = bdcr_mode_t'(cfg3_q[`BDCR_MODE_LSB +: 2]);
    wire logic [1:0] load_type = cfg2_q[`BDCR_LOAD_LSB +: 2];
    wire logic ola_block = (mode == BDCR_MODE_INDEP) & (load_type == `BDCR_LOAD_LOW_SIDE);
    wire logic ola_en_d = cfg1_q[`BDCR_OLA_EN_BIT] & ~ola_block;
    wire logic [1:0] ov_sel = cfg1_q[`BDCR_OV_SEL_LSB +: 2];
    wire logic [1:0] regulation_off_time_sel = cfg3_q[`BDCR_REGULATION_OFF_TIME_LSB +: 2];
    wire logic [1:0] overcurrent_filter_select = cfg4_q[`BDCR_TOCP_LSB +: 2];
    wire logic [1:0] overcurrent_threshold_select = cfg4_q[`BDCR_OVERCURRENT_THRESHOLD_SELECT_LSB +: 2];

    wire logic [10:0] regulation_off_time_d = (regulation_off_time_sel == 2'h0) ? REGULATION_OFF_TIME_C0 :
                               (regulation_off_time_sel == 2'h1) ? REGULATION_OFF_TIME_C1 :
                               (regulation_off_time_sel == 2'h2) ? REGULATION_OFF_TIME_C2 : REGULATION_OFF_TIME_C3;
    wire logic [7:0] tocp_d = (overcurrent_filter_select == 2'h0) ? TOCP_C0 :
                              (overcurrent_filter_select == 2'h1) ? TOCP_C1 :
                              (overcurrent_filter_select == 2'h2) ? TOCP_C2 : TOCP_C3;
    wire logic [6:0] pct_d = (overcurrent_threshold_select == 2'h0) ? `BDCR_PCT_100 :
                             (overcurrent_threshold_select == 2'h2) ? `BDCR_PCT_75 : `BDCR_PCT_50;

    bdcr_pins_t pins_eff_d;
    assign pins_eff_d.shutoff = pin_unlocked ?
        combine(cfg4_q[`BDCR_SHUT_SEL_BIT], pins_s2_q.shutoff, ovr_q[`BDCR_OVR_SHUT_BIT]) :
        pins_s2_q.shutoff;
    assign pins_eff_d.in1 = pin_unlocked ?
        combine(cfg4_q[`BDCR_IN1_SEL_BIT], pins_s2_q.in1, ovr_q[`BDCR_OVR_IN1_BIT]) :
        pins_s2_q.in1;
    assign pins_eff_d.in2 = pin_unlocked ?
        combine(cfg4_q[`BDCR_IN2_SEL_BIT], pins_s2_q.in2, ovr_q[`BDCR_OVR_IN2_BIT]) :
        pins_s2_q.in2;

    ////////////////////////////////////////////////////////////////////////////
    // registered outputs

    always_ff @(posedge i_clk or negedge i_rst_n)
    begin
        if (!i_rst_n)
        begin
            o_rdata <= 8'h00;
            o_open_load_active_enable <= 1'b0;
            o_overvoltage_threshold_select <= 2'h0;
            o_overvoltage_monitor_enable <= 1'b1;
            o_spread_spectrum_enable <= 1'b0;
            o_overcurrent_retry <= 1'b0;
            o_overtemp_retry <= 1'b0;
            o_overvoltage_retry <= 1'b0;
            o_undervoltage_retry <= 1'b0;
            o_open_load_retry <= 1'b0;
            o_pwm_coast_extend <= 1'b0;
            o_load_type_select <= 2'h0;
            o_current_trip_level <= 3'h0;
            o_regulation_off_time_cycles <= REGULATION_OFF_TIME_C1;
            o_slew_rate_select <= 3'h0;
            o_bridge_mode <= BDCR_MODE_PHEN;
            o_overcurrent_filter_cycles <= TOCP_C0;
            o_overcurrent_threshold_pct <= `BDCR_PCT_100;
            o_cfg_locked <= 1'b0;
            o_pin_override_unlocked <= 1'b0;
            o_pins_eff <= '0;
        end
        else
        begin
            o_rdata <= i_req.rd ? rdata_d : 8'h00;
            o_open_load_active_enable <= ola_en_d;
            o_overvoltage_threshold_select <= ov_sel;
            o_overvoltage_monitor_enable <= (ov_sel != 2'h3);
            o_spread_spectrum_enable <= ~cfg1_q[`BDCR_SPREAD_SPECTRUM_DISABLE_BIT];
            o_overcurrent_retry <= cfg1_q[`BDCR_OVERCURRENT_RETRY_BIT];
            o_overtemp_retry <= cfg1_q[`BDCR_OVERTEMP_RETRY_BIT];
            o_overvoltage_retry <= cfg1_q[`BDCR_OV_RETRY_BIT];
            o_undervoltage_retry <= cfg1_q[`BDCR_OV_RETRY_BIT] & `BDCR_EXT_LOGIC_RAIL;
            o_open_load_retry <= cfg1_q[`BDCR_OPEN_LOAD_RETRY_BIT];
            o_pwm_coast_extend <= cfg2_q[`BDCR_PWM_EXT_BIT];
            o_load_type_select <= load_type;
            o_current_trip_level <= cfg2_q[`BDCR_CURRENT_TRIP_LSB +: 3];
            o_regulation_off_time_cycles <= regulation_off_time_d;
            o_slew_rate_select <= cfg3_q[`BDCR_SR_LSB +: 3];
            o_bridge_mode <= mode;
            o_overcurrent_filter_cycles <= tocp_d;
            o_overcurrent_threshold_pct <= pct_d;
            o_cfg_locked <= cfg_locked;
            o_pin_override_unlocked <= pin_unlocked;
            o_pins_eff <= pins_eff_d;
        end
    end

endmodule

// File: verification/bdcr_config_regs_asserts.sv
// assertion checker for the bridge driver configuration bank
`timescale 1ns/1ps
module bdcr_config_regs_asserts
    import bdcr_pkg::*;
(
    input wire logic i_clk,
    input wire logic i_rst_n,
    input wire bdcr_req_t i_req,
    input wire logic [7:0] o_rdata,
    input wire logic o_open_load_active_enable,
    input wire logic [1:0] o_overvoltage_threshold_select,
    input wire logic o_overvoltage_monitor_enable,
    input wire logic o_spread_spectrum_enable,
    input wire logic o_overcurrent_retry,
    input wire logic o_overtemp_retry,
    input wire logic o_overvoltage_retry,
    input wire logic o_undervoltage_retry,
    input wire logic o_open_load_retry,
    input wire logic [1:0] o_load_type_select,
    input wire logic [10:0] o_regulation_off_time_cycles,
    input wire bdcr_mode_t o_bridge_mode,
    input wire logic [6:0] o_overcurrent_threshold_pct,
    input wire logic o_cfg_locked
);
    ////////////////////////////////////////////////////////////////////////////////
    // lock write one cycle back: o_cfg_locked lags the lock register
    logic lock_wr_q;
    always_ff @(posedge i_clk or negedge i_rst_n)
    begin
        if (!i_rst_n)
            lock_wr_q <= 1'b0;
        else
            lock_wr_q <= i_req.wr && i_req.addr == 6'h08;
    end
    wire logic open_w = i_req.wr && !o_cfg_locked && !lock_wr_q;
    wire logic wr1 = open_w && i_req.addr == 6'h0a;
    wire logic wr3 = open_w && i_req.addr == 6'h0c;
    wire logic wr4 = open_w && i_req.addr == 6'h0d;
    default clocking @(posedge i_clk); endclocking
    default disable iff (!i_rst_n);
    ////////////////////////////////////////////////////////////////////////////////
    chk_rd_unused: assert property (i_req.rd && i_req.addr == 6'h0b |=> o_rdata[4:3] == 2'h0)
        else $error("unused bits read nonzero");
    chk_ola_gate: assert property ((o_bridge_mode == BDCR_MODE_INDEP && o_load_type_select == 2'h1)
        |-> !o_open_load_active_enable) else $error("open load on with low-side load");
    chk_ov_monitor: assert property (o_overvoltage_monitor_enable == (o_overvoltage_threshold_select != 2'h3))
        else $error("over-voltage monitor enable wrong");
    chk_uv_follow: assert property (o_undervoltage_retry == o_overvoltage_retry)
        else $error("under-voltage reaction differs");
    chk_retry_bits: assert property (wr1 |=> ##1 {o_overcurrent_retry, o_overtemp_retry,
        o_overvoltage_retry, o_open_load_retry} == $past(i_req.wdata[3:0], 2)) else $error("retry bits wrong");
    chk_ssc_enable: assert property (wr1 |=> ##1 o_spread_spectrum_enable == !$past(i_req.wdata[4], 2))
        else $error("spread spectrum enable wrong");
    chk_off_time: assert property (wr3 |=> ##1 o_regulation_off_time_cycles ==
        11'd400 + 11'd200 * $past(i_req.wdata[7:6], 2)) else $error("off time wrong");
    chk_ocp_pct: assert property (wr4 |=> ##1 o_overcurrent_threshold_pct ==
        ($past(i_req.wdata[4:3], 2) == 2'h0 ? 7'h64 : $past(i_req.wdata[4:3], 2) == 2'h2 ? 7'h4b : 7'h32))
        else $error("threshold percent wrong");
    chk_lock_hold: assert property (i_req.wr && i_req.addr == 6'h0a && o_cfg_locked && !lock_wr_q
        |=> ##1 $stable(o_overcurrent_retry)) else $error("locked register changed");
endmodule

bind bdcr_config_regs bdcr_config_regs_asserts u_asserts (.i_clk(i_clk), .i_rst_n(i_rst_n),
    .i_req(i_req), .o_rdata(o_rdata), .o_open_load_active_enable(o_open_load_active_enable),
    .o_overvoltage_threshold_select(o_overvoltage_threshold_select),
    .o_overvoltage_monitor_enable(o_overvoltage_monitor_enable),
    .o_spread_spectrum_enable(o_spread_spectrum_enable), .o_overcurrent_retry(o_overcurrent_retry),
    .o_overtemp_retry(o_overtemp_retry), .o_overvoltage_retry(o_overvoltage_retry),
    .o_undervoltage_retry(o_undervoltage_retry), .o_open_load_retry(o_open_load_retry),
    .o_load_type_select(o_load_type_select), .o_bridge_mode(o_bridge_mode),
    .o_regulation_off_time_cycles(o_regulation_off_time_cycles),
    .o_overcurrent_threshold_pct(o_overcurrent_threshold_pct), .o_cfg_locked(o_cfg_locked));

// File: verification/tb_bdcr_config_regs.sv
// self-checking bench for the bridge driver configuration bank
`timescale 1ns/1ps
module tb_bdcr_config_regs
    import bdcr_pkg::*;
;
    logic i_clk, i_rst_n, open_load_active, ssc, ovm, locked, pin_unl;
    bdcr_req_t i_req;
    bdcr_pins_t i_pins, eff;
    logic [7:0] o_rdata;
    logic coast, ocr, otr, ovr, olr;
    logic [1:0] ovsel, ltype;
    logic [2:0] current_trip, srs;
    logic [10:0] regulation_off_time;
    bdcr_mode_t bmode;
    logic [7:0] filt;
    logic [6:0] pct;
    int n_errors = 0;
    int check_count = 0;
    int cycles = 0;
    bdcr_config_regs DUT (.i_clk(i_clk), .i_rst_n(i_rst_n), .i_req(i_req), .i_pins(i_pins),
        .o_rdata(o_rdata), .o_open_load_active_enable(open_load_active), .o_overvoltage_threshold_select(ovsel),
        .o_overvoltage_monitor_enable(ovm), .o_spread_spectrum_enable(ssc), .o_overcurrent_retry(ocr),
        .o_overtemp_retry(otr), .o_overvoltage_retry(ovr), .o_undervoltage_retry(),
        .o_open_load_retry(olr), .o_pwm_coast_extend(coast), .o_load_type_select(ltype),
        .o_current_trip_level(current_trip), .o_regulation_off_time_cycles(regulation_off_time),
        .o_slew_rate_select(srs), .o_bridge_mode(bmode), .o_overcurrent_filter_cycles(filt),
        .o_overcurrent_threshold_pct(pct), .o_cfg_locked(locked),
        .o_pin_override_unlocked(pin_unl), .o_pins_eff(eff));
    ////////////////////////////////////////////////////////////////////////////////
    task automatic print_verdict();
        $display("errors %0d checks %0d", n_errors, check_count);
        if (n_errors == 0 && check_count > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask
    task automatic chk(input logic ok, input string msg);
        check_count++;
        if (ok !== 1'b1)
        begin
            n_errors++;
            $display("[ERR] %0t %s", $time, msg);
        end
    endtask
    task automatic wr(input logic [5:0] a, input logic [7:0] d);
        @(posedge i_clk);
        i_req <= '{1'b1, 1'b0, a, d};
        @(posedge i_clk);
        i_req <= '0;
    endtask
    task automatic rd(input logic [5:0] a, input logic [7:0] e);
        @(posedge i_clk);
        i_req <= '{1'b0, 1'b1, a, 8'h00};
        @(posedge i_clk);
        i_req <= '0;
        #1;
        chk(o_rdata === e, "read data mismatch");
    endtask
    task automatic settle(input int n);
        repeat (n) @(posedge i_clk);
        #1;
    endtask
    ////////////////////////////////////////////////////////////////////////////////
    task automatic t_reset();
        rd(6'h0a, 8'h10);
        rd(6'h0b, 8'h00);
        rd(6'h0c, 8'h40);
        rd(6'h0d, 8'h04);
        chk(ssc === 1'b0 && locked === 1'b0 && pin_unl === 1'b0, "reset state");
    endtask
    task automatic t_cfg1();
        for (int i = 0; i < 4; i++)
        begin
            wr(6'h0a, {1'b1, i[1:0], 5'h0f});
            settle(2);
            chk(ovm === (i != 3) && open_load_active === 1'b1 && ssc === 1'b1, "config one decode");
        end
        wr(6'h0a, 8'h1a);
        settle(2);
        chk(open_load_active === 1'b0 && ssc === 1'b0, "enables off");
        rd(6'h0a, 8'h1a);
    endtask
    task automatic t_masks();
        wr(6'h0b, 8'hff);
        wr(6'h0c, 8'hff);
        wr(6'h0d, 8'hff);
        rd(6'h0b, 8'he7);
        rd(6'h0c, 8'hdf);
        rd(6'h0d, 8'hdf);
        rd(6'h3f, 8'h00);
    endtask
    task automatic t_ola_gate();
        wr(6'h0c, 8'h02);
        wr(6'h0b, 8'h20);
        wr(6'h0a, 8'h80);
        settle(2);
        chk(open_load_active === 1'b0, "open load with low-side load");
        wr(6'h0c, 8'h00);
        settle(2);
        chk(open_load_active === 1'b1, "open load enable");
    endtask
    task automatic t_lock();
        wr(6'h08, 8'h0a);
        wr(6'h0a, 8'h00);
        rd(6'h0a, 8'h80);
        chk(locked === 1'b1, "lock flag");
        wr(6'h08, 8'h0b);
        wr(6'h0a, 8'h13);
        rd(6'h0a, 8'h13);
    endtask
    task automatic t_fields();
        settle(1);
        chk(ovsel === 2'h0 && {ocr, otr, ovr, olr} === 4'h3, "retry fields");
        wr(6'h0b, 8'ha5);
        wr(6'h0c, 8'h9e);
        wr(6'h0d, 8'hc0);
        settle(2);
        chk(coast === 1'b1 && ltype === 2'h1, "coast and load type");
        chk(current_trip === 3'h5, "current trip level");
        chk(regulation_off_time === 11'd800, "off time");
        chk(srs === 3'h7, "slew rate");
        chk(bmode === BDCR_MODE_INDEP, "bridge mode");
        chk(filt === 8'd4 && pct === 7'd100, "filter min and full threshold");
        wr(6'h0d, 8'h48);
        settle(2);
        chk(filt === 8'd60 && pct === 7'd50, "filter and half threshold");
    endtask
    task automatic t_pins();
        @(posedge i_clk);
        i_pins <= 3'b101;
        settle(6);
        chk(eff === 3'b101, "pins pass while locked");
        wr(6'h08, 8'h10);
        wr(6'h09, 8'h00);
        wr(6'h0d, 8'h00);
        settle(6);
        chk(eff === 3'b101 && pin_unl === 1'b1, "or with zero");
        wr(6'h0d, 8'h07);
        settle(6);
        chk(eff === 3'b000, "and with zero");
        wr(6'h09, 8'h0b);
        settle(6);
        chk(eff === 3'b101, "and with one");
        wr(6'h0d, 8'h00);
        settle(6);
        chk(eff === 3'b111, "or with one");
        wr(6'h08, 8'h08);
        settle(6);
        chk(eff === 3'b101 && pin_unl === 1'b0, "relocked pins");
    endtask
    ////////////////////////////////////////////////////////////////////////////////
    initial
    begin
        i_clk = 1'b0;
        forever #25 i_clk = ~i_clk;
    end
    always @(posedge i_clk)
    begin
        cycles <= cycles + 1;
        if (cycles == 3000)
        begin
            n_errors++;
            print_verdict();
        end
    end
    initial
    begin
        i_rst_n = 1'b0;
        i_req = '0;
        i_pins = '0;
        repeat (3) @(posedge i_clk);
        i_rst_n <= 1'b1;
        t_reset();
        t_cfg1();
        t_masks();
        t_ola_gate();
        t_lock();
        t_fields();
        t_pins();
        print_verdict();
    end
endmodule
